// *** design/flash_unlock_pkg.sv ***
// Package for the flash unlock and target address block.
// Assumes a single 100 MHz clock domain and a plain register port.
package flash_unlock_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h00;
  localparam logic [7:0] OFS_TARGET_ADDRESS = 8'h04;
  localparam logic [7:0] OFS_OPERATION = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  localparam logic [31:0] TARGET_ADDRESS_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ********************************
  // Unlock keys, arbitrary values
  // ********************************
  localparam logic [31:0] KEY_FIRST = 32'hAA99_6655;
  localparam logic [31:0] KEY_SECOND = 32'h5566_99AA;

  // ********************************
  // Operation control and status fields
  // ********************************
  localparam int OP_CODE_LSB = 0;
  localparam int OP_START_BIT = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_UNLOCKED_BIT = 2;

  typedef enum logic [1:0] {
    OP_BULK_ERASE = 2'h0,
    OP_PAGE_ERASE = 2'h1,
    OP_ROW_PROGRAM = 2'h2,
    OP_WORD_PROGRAM = 2'h3
  } flash_op_t;

  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_FIRST = 3'b010,
    UL_OPEN = 3'b100
  } unlock_state_t;

  // Request handed to the flash array
  typedef struct packed {
    logic start;
    flash_op_t op;
    logic useAddress;
    logic [31:0] address;
  } flash_req_t;

endpackage : flash_unlock_pkg

// *** design/flash_unlock_and_address.sv ***
// Unlock key register, target address register and start gate for flash.
// Assumes a register port on clk and an array that reports done as a pulse.
//
// Operation
// - Unlock key register is write-only and always reads as zero.
// - Key writes form the unlock sequence guarding flash from stray writes.
// - Target address register is 32-bit read/write, cleared on reset.
// - Bulk erase ignores the target address.
// - Page erase uses the target address to pick the page.
// - Row program uses the target address to pick the row.
// - Word program uses the target address to pick the word.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module flash_unlock_and_address (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // Flash array side
  output flash_unlock_pkg::flash_req_t flashReq,
  input wire logic flashDone
);

  // ********************************
  // Helpers
  // ********************************
  // Operation code field of a word written to the operation register
  function automatic flash_unlock_pkg::flash_op_t opField(
    input logic [31:0] word
  );
    return flash_unlock_pkg::flash_op_t'(
      word[flash_unlock_pkg::OP_CODE_LSB +: 2]);
  endfunction : opField

  // Bulk erase is the only operation that ignores the target address
  function automatic logic needsAddress(
    input flash_unlock_pkg::flash_op_t op
  );
    return op != flash_unlock_pkg::OP_BULK_ERASE;
  endfunction : needsAddress

  // Status word; bits not listed read as zero
  function automatic logic [31:0] statusWord(
    input logic unlocked,
    input logic refusedFlag,
    input logic busyFlag
  );
    logic [31:0] word;
    word = flash_unlock_pkg::READ_ZERO;
    word[flash_unlock_pkg::ST_BUSY_BIT] = busyFlag;
    word[flash_unlock_pkg::ST_REFUSED_BIT] = refusedFlag;
    word[flash_unlock_pkg::ST_UNLOCKED_BIT] = unlocked;
    return word;
  endfunction : statusWord

  // ********************************
  // Register decode
  // ********************************
  logic wrKey;
  logic wrAddr;
  logic wrOp;
  logic startReq;
  assign wrKey = regWrite && regAddr == flash_unlock_pkg::OFS_UNLOCK_KEY;
  assign wrAddr = regWrite
    && regAddr == flash_unlock_pkg::OFS_TARGET_ADDRESS;
  assign wrOp = regWrite && regAddr == flash_unlock_pkg::OFS_OPERATION;
  assign startReq = wrOp && regWdata[flash_unlock_pkg::OP_START_BIT];

  logic [31:0] targetAddress;
  flash_unlock_pkg::flash_op_t opSelect;
  flash_unlock_pkg::unlock_state_t unlockState;
  logic busy;
  logic refused;

  // ********************************
  // Unlock sequence
  // ********************************
  // Any other register write breaks the sequence, so the start must come
  // as the very next write after the second key.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlockState <= flash_unlock_pkg::UL_IDLE;
    end else if (regWrite) begin
      unique case (unlockState)
        flash_unlock_pkg::UL_IDLE: begin
          if (wrKey && regWdata == flash_unlock_pkg::KEY_FIRST) begin
            unlockState <= flash_unlock_pkg::UL_FIRST;
          end
        end
        flash_unlock_pkg::UL_FIRST: begin
          if (wrKey && regWdata == flash_unlock_pkg::KEY_SECOND) begin
            unlockState <= flash_unlock_pkg::UL_OPEN;
          end else begin
            unlockState <= flash_unlock_pkg::UL_IDLE;
          end
        end
        flash_unlock_pkg::UL_OPEN: begin
          unlockState <= flash_unlock_pkg::UL_IDLE;
        end
        default: begin
          unlockState <= flash_unlock_pkg::UL_IDLE;
        end
      endcase
    end
  end

  // ********************************
  // Target address and operation
  // ********************************
  // Address is frozen while busy so the array sees a stable target.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      targetAddress <= flash_unlock_pkg::TARGET_ADDRESS_RESET;
    end else if (wrAddr && !busy) begin
      targetAddress <= regWdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opSelect <= flash_unlock_pkg::OP_BULK_ERASE;
    end else if (wrOp && !busy) begin
      opSelect <= opField(regWdata);
    end
  end

  // ********************************
  // Start gate
  // ********************************
  // Unlock is consumed by the start write itself, so a second start
  // always needs a fresh key pair.
  logic unlocked;
  logic grant;
  assign unlocked = unlockState == flash_unlock_pkg::UL_OPEN;
  assign grant = startReq && !busy && unlocked;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (grant) begin
      busy <= 1'b1;
    end else if (flashDone) begin
      busy <= 1'b0;
    end
  end

  // Sticky; a new refusal in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refused <= 1'b0;
    end else if (startReq && !grant) begin
      refused <= 1'b1;
    end else if (wrOp) begin
      refused <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flashReq <= '0;
    end else begin
      flashReq.start <= grant;
      // Fields hold from the grant so the array may sample them late
      if (grant) begin
        flashReq.op <= opField(regWdata);
        if (needsAddress(opField(regWdata))) begin
          flashReq.useAddress <= 1'b1;
          flashReq.address <= targetAddress;
        end else begin
          // Zeroed so a stale target never reaches a bulk erase
          flashReq.useAddress <= 1'b0;
          flashReq.address <= 32'h0000_0000;
        end
      end
    end
  end

  // ********************************
  // Read data
  // ********************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= flash_unlock_pkg::READ_ZERO;
    end else if (regRead) begin
      unique case (regAddr)
        flash_unlock_pkg::OFS_UNLOCK_KEY: begin
          regRdata <= flash_unlock_pkg::READ_ZERO;
        end
        flash_unlock_pkg::OFS_TARGET_ADDRESS: begin
          regRdata <= targetAddress;
        end
        flash_unlock_pkg::OFS_OPERATION: begin
          regRdata <= {30'h0000_0000, opSelect};
        end
        flash_unlock_pkg::OFS_STATUS: begin
          regRdata <= statusWord(unlocked, refused, busy);
        end
        default: begin
          regRdata <= flash_unlock_pkg::READ_ZERO;
        end
      endcase
    end else begin
      regRdata <= flash_unlock_pkg::READ_ZERO;
    end
  end

endmodule : flash_unlock_and_address

// *** tb/flash_array_model.sv ***
// Flash array model: answers every start with a done pulse.
// Assumes flashReq and flashDone share clk.
`timescale 1ns/10ps
module flash_array_model #(parameter int LAT = 5) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request and answer
  input wire flash_unlock_pkg::flash_req_t flashReq,
  output logic flashDone
);
  int cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt <= 0;
    else if (flashReq.start) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign flashDone = (cnt == 1);
endmodule : flash_array_model

// *** tb/flash_unlock_sva.sv ***
// Checker on the ports of the flash unlock block.
// Assumes one clock domain; bound at the foot of this file.
`timescale 1ns/10ps
module flash_unlock_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port and flash side
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire flash_unlock_pkg::flash_req_t flashReq,
  input wire logic flashDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire go = flashReq.start;
  wire [1:0] op = flashReq.op;
  wire kAd = regAddr == flash_unlock_pkg::OFS_UNLOCK_KEY;
  wire oAd = regAddr == flash_unlock_pkg::OFS_OPERATION;
  AST_KEY_RD: assert property (regRead && kAd |=> regRdata == '0)
    else $error("key read not zero");
  AST_RD_IDLE: assert property (!regRead |=> regRdata == '0)
    else $error("read data outside read");
  AST_BULK: assert property (go && op == 2'h0 |->
    !flashReq.useAddress && flashReq.address == '0)
    else $error("bulk erase used address");
  AST_PAGE: assert property (go && op == 2'h1 |-> flashReq.useAddress)
    else $error("page erase lost address");
  AST_ROW: assert property (go && op == 2'h2 |-> flashReq.useAddress)
    else $error("row program lost address");
  AST_WORD: assert property (go && op == 2'h3 |-> flashReq.useAddress)
    else $error("word program lost address");
  AST_PULSE: assert property (go |=> !go)
    else $error("start longer than one cycle");
  AST_GATE: assert property (go |-> $past(regWrite && oAd && regWdata[4])
    && $past(regWdata[1:0]) == op) else $error("start without command");
  AST_KEY_W: assert property (regWrite && kAd |=> !go)
    else $error("key write started flash");
  cover property (go && op == 2'h1);
  cover property (flashDone);
  cover property (regRead && kAd);
endmodule : flash_unlock_sva
bind flash_unlock_and_address flash_unlock_sva flash_unlock_sva_inst (
  .clk, .rst_b, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
  .flashReq, .flashDone);

// *** tb/tb_top.sv ***
// Bench: register tasks drive unlock, address and start sequences.
// Assumes the design package and the flash array model.
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] AD = flash_unlock_pkg::OFS_TARGET_ADDRESS;
  localparam logic [7:0] KA = flash_unlock_pkg::OFS_UNLOCK_KEY;
  localparam logic [7:0] OA = flash_unlock_pkg::OFS_OPERATION;
  localparam logic [7:0] SA = flash_unlock_pkg::OFS_STATUS;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, q, a;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic flashDone;
  flash_unlock_pkg::flash_req_t flashReq, lastReq;
  int nMismatch = 0, checks = 0, nStart = 0, cyc = 0;
  always #5 clk = ~clk;
  flash_unlock_and_address flash_unlock_and_address_inst (.clk, .rst_b,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .flashReq,
    .flashDone);
  flash_array_model flash_array_model_inst (.clk, .rst_b, .flashReq,
    .flashDone);
  task automatic conclude;
    $display("mismatches %0d checks %0d", nMismatch, checks);
    if (nMismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Hang guard, far above the roughly 150 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (flashReq.start === 1'b1) begin
      nStart <= nStart + 1;
      lastReq <= flashReq;
    end
    if (cyc == 3000) begin
      nMismatch++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      nMismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    regAddr <= ad;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    v = regRdata;
    @(posedge clk);
  endtask : rd
  // Refused starts skip the second key, so they must not pulse
  task automatic run(input logic [1:0] op, input logic ok);
    int n0;
    n0 = nStart;
    wr(KA, flash_unlock_pkg::KEY_FIRST);
    if (ok) wr(KA, flash_unlock_pkg::KEY_SECOND);
    wr(flash_unlock_pkg::OFS_OPERATION, {27'h0, 1'b1, 2'h0, op});
    @(posedge clk);
    check(32'(nStart - n0), {31'h0, ok});
    repeat (10) @(posedge clk);
  endtask : run
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(AD, q);
    check(q, 32'h0);
    wr(KA, 32'hFFFF_FFFF);
    rd(KA, q);
    check(q, 32'h0);
    rd(8'h10, q);
    check(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      a = 32'hA5C3_0F10 + 32'(i);
      wr(AD, a);
      rd(AD, q);
      check(q, a);
      run(2'(i), 1'b1);
      check({30'h0, lastReq.op}, 32'(i));
      check({31'h0, lastReq.useAddress}, {31'h0, i != 0});
      check(lastReq.address, (i != 0) ? a : 32'h0);
    end
    run(2'h1, 1'b0);
    rd(flash_unlock_pkg::OFS_STATUS, q);
    check({31'h0, q[flash_unlock_pkg::ST_REFUSED_BIT]}, 32'h1);
    // Plain operation write clears the refusal and reads back the code
    wr(OA, 32'h0000_0002);
    rd(SA, q);
    check(q, 32'h0);
    rd(OA, q);
    check(q, 32'h2);
    // While busy the address is frozen and status shows busy only
    wr(KA, flash_unlock_pkg::KEY_FIRST);
    wr(KA, flash_unlock_pkg::KEY_SECOND);
    wr(OA, 32'h0000_0013);
    wr(AD, 32'h0000_1234);
    rd(SA, q);
    check(q, 32'h1);
    repeat (10) @(posedge clk);
    rd(AD, q);
    check(q, 32'hA5C3_0F13);
    conclude();
  end
endmodule : tb_top
